// ==== core/rtca_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - prescaler divides slow reference down to one per-second tick shared by clock counters and watchdog
// - ref_freq_select set picks the higher-crystal divisor; clear picks the lower one
// - prescaler taps give a per-second event and eight periodic rate events
// - seconds and minutes six bits, hours five bits, day nine bits
// - seconds step each tick; each higher counter steps on rollover below it
// - time counters readable at any moment without disturbing counting
// - written values never range checked; out-of-range value clears on next increment
// - seconds or minutes at 59 clear to 00, carry, raise rollover event
// - hours at 23 clear to 00 on minute carry, advance day, raise day event
// - alarm holds seconds, minutes, hours in one register, day in another
// - match of time and alarm sets match flag; interrupt only if enabled
// - enabled alarm fires again on every later match until changed or disabled
// - fifteen event sources merge onto three interrupt outputs
// - every event source has its own bit in the interrupt enable register
// - clock events feed rtc line, rate events real-time line, watchdog its own
// - watchdog can drive a system reset output
// - clock counters gated by enable bit set at reset; watchdog separately enabled and keeps prescaler and rates running
// - slow reference keeps counting in every reduced-power mode
// - time register has hours 28..24, minutes 21..16, seconds 5..0, rest zero
// - writing time or day registers replaces counters at once; counting continues
//////////////////////////////////////////////////////////////////////////////
package rtca_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_TIME      = 8'h00;
   localparam logic [7:0] ADDR_MATCH     = 8'h04;
   localparam logic [7:0] ADDR_WDOG      = 8'h08;
   localparam logic [7:0] ADDR_CTRL      = 8'h0c;
   localparam logic [7:0] ADDR_STATUS    = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
   localparam logic [7:0] ADDR_STOPW     = 8'h18;
   localparam logic [7:0] ADDR_DAY       = 8'h1c;
   localparam logic [7:0] ADDR_MATCH_DAY = 8'h20;

   // control register bits
   localparam int CTRL_RTC_EN   = 7;
   localparam int CTRL_REF_FREQ = 5;
   localparam int CTRL_DAY_CMP  = 0;

   // watchdog register bits
   localparam int WDOG_EN       = 0;
   localparam int WDOG_IRQ_MODE = 1;
   localparam int WDOG_CNT_LO   = 8;

   // status and enable bit positions
   localparam int EV_SW   = 0;
   localparam int EV_MIN  = 1;
   localparam int EV_ALM  = 2;
   localparam int EV_DAY  = 3;
   localparam int EV_SEC  = 4;
   localparam int EV_HR   = 5;
   localparam int EV_WDOG = 7;
   localparam int EV_RTE0 = 8;
   localparam int N_RATES = 8;
   localparam int EV_W    = 16;

   localparam logic [EV_W-1:0] MASK_RTC  = 16'h003f;
   localparam logic [EV_W-1:0] MASK_WDOG = 16'h0080;
   localparam logic [EV_W-1:0] MASK_RT   = 16'hff00;

   // counter limits and field layout
   localparam logic [5:0] SEC_MAX     = 6'h3b;
   localparam logic [5:0] MIN_MAX     = 6'h3b;
   localparam logic [5:0] HOUR_MAX    = 6'h17;
   localparam logic [5:0] STOPW_EXPD  = 6'h3f;
   localparam logic [1:0] WDOG_LIMIT  = 2'h2;
   localparam int         HOUR_LO     = 24;
   localparam int         MIN_LO      = 16;
   localparam int         SEC_LO      = 0;
   localparam int         DAY_W       = 9;

   // prescaler divisors in reference cycles per second
   localparam int DIV_LOW_REF  = 32768;
   localparam int DIV_HIGH_REF = 38400;
   localparam int PRESC_W      = 16;
   localparam int RATE_TAP0    = 7;

   typedef struct packed {
      logic [4:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
   } rtca_tod_t;

   typedef struct packed {
      logic [5:0] value;
      logic       carry;
   } rtca_step_t;

endpackage

// ==== core/rtca_core.sv ====
// The register offsets and the APB slave port are this design's own decisions.
module rtca_core
   import rtca_pkg::*;
#(
   parameter int DIV_LOW  = DIV_LOW_REF,
   parameter int DIV_HIGH = DIV_HIGH_REF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slow_ref_clock,
   output logic             irq_wdog,
   output logic             irq_rt,
   output logic             irq_rtc,
   output logic             wdog_reset
);

   //////////////////////////////////////////////////////////////////////////
   // functions

   // one increment of a bounded counter
   function automatic rtca_step_t step(input logic [5:0] v, input logic [5:0] lim);
      rtca_step_t s;
      s.value = v + 6'h01;
      s.carry = 1'b0;
      if (v == lim) begin
         s.value = 6'h00;
         s.carry = 1'b1;
      end else if (v > lim) begin
         s.value = 6'h00;
      end
      return s;
   endfunction

   // address decode
   function automatic logic mapped(input logic [7:0] a);
      return a == ADDR_TIME || a == ADDR_MATCH || a == ADDR_WDOG || a == ADDR_CTRL ||
             a == ADDR_STATUS || a == ADDR_IRQ_EN || a == ADDR_STOPW || a == ADDR_DAY ||
             a == ADDR_MATCH_DAY;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // declarations

   localparam logic [PRESC_W-1:0] DIV_LOW_M1  = PRESC_W'(DIV_LOW - 1);
   localparam logic [PRESC_W-1:0] DIV_HIGH_M1 = PRESC_W'(DIV_HIGH - 1);

   logic               ref_q;
   logic               ref_prev;
   logic               ref_edge;
   logic [PRESC_W-1:0] presc;
   logic [PRESC_W-1:0] rate_cnt;
   logic               per_second_tick;
   logic               presc_run;
   logic [7:0]         rtc_control_reg;
   rtca_tod_t          wall_clock_counters;
   logic [DAY_W-1:0]   day_count;
   rtca_tod_t          match_time;
   logic [DAY_W-1:0]   match_day_field;
   logic [EV_W-1:0]    rtc_irq_status_reg;
   logic [EV_W-1:0]    rtc_irq_enable_reg;
   logic [EV_W-1:0]    events;
   logic [5:0]         stopw;
   logic               wdog_en;
   logic               wdog_irq_mode;
   logic [1:0]         wdog_cnt;
   logic               wdog_expire;
   logic               match_now;
   logic               match_prev;
   logic               wr;
   rtca_step_t         sec_s;
   rtca_step_t         min_s;
   rtca_step_t         hour_s;
   logic               min_tick;
   logic               hour_tick;
   logic               day_tick;
   logic [N_RATES-1:0] rate_ev;
   logic [31:0]        next_prdata;

   assign wr = psel && penable && pready && pwrite;

   //////////////////////////////////////////////////////////////////////////
   // reference edge detection; reference runs in every power mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q    <= 1'b0;
         ref_prev <= 1'b0;
      end else begin
         ref_q    <= slow_ref_clock;
         ref_prev <= ref_q;
      end
   end

   assign ref_edge  = ref_q && !ref_prev;
   assign presc_run = rtc_control_reg[CTRL_RTC_EN] || wdog_en;

   // prescaler down to one tick per second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc           <= '0;
         per_second_tick <= 1'b0;
      end else begin
         per_second_tick <= 1'b0;
         if (presc_run && ref_edge) begin
            if (presc == (rtc_control_reg[CTRL_REF_FREQ] ? DIV_HIGH_M1 : DIV_LOW_M1)) begin
               presc           <= '0;
               per_second_tick <= 1'b1;
            end else begin
               presc <= presc + 1'b1;
            end
         end
      end
   end

   // free tap counter for the periodic rates
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_cnt <= '0;
      end else if (presc_run && ref_edge) begin
         rate_cnt <= rate_cnt + 1'b1;
      end
   end

   // rate k fires when the low tap bits are all ones
   always_comb begin
      for (int k = 0; k < N_RATES; k++) begin
         rate_ev[k] = presc_run && ref_edge && (&(rate_cnt | ~((PRESC_W'(1) << (RATE_TAP0 + k)) - 1'b1)));
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // time of day cascade
   assign sec_s     = step(wall_clock_counters.seconds, SEC_MAX);
   assign min_s     = step(wall_clock_counters.minutes, MIN_MAX);
   assign hour_s    = step({1'b0, wall_clock_counters.hours}, HOUR_MAX);
   assign min_tick  = per_second_tick && rtc_control_reg[CTRL_RTC_EN] && sec_s.carry;
   assign hour_tick = min_tick && min_s.carry;
   assign day_tick  = hour_tick && hour_s.carry;

   // counters; a software write overrides a coincident tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wall_clock_counters <= '0;
      end else if (wr && paddr == ADDR_TIME) begin
         wall_clock_counters.hours   <= pwdata[HOUR_LO +: 5];
         wall_clock_counters.minutes <= pwdata[MIN_LO +: 6];
         wall_clock_counters.seconds <= pwdata[SEC_LO +: 6];
      end else if (per_second_tick && rtc_control_reg[CTRL_RTC_EN]) begin
         wall_clock_counters.seconds <= sec_s.value;
         if (min_tick) begin
            wall_clock_counters.minutes <= min_s.value;
         end
         if (hour_tick) begin
            wall_clock_counters.hours <= hour_s.value[4:0];
         end
      end
   end

   // day counter wraps silently at full count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         day_count <= '0;
      end else if (wr && paddr == ADDR_DAY) begin
         day_count <= pwdata[DAY_W-1:0];
      end else if (day_tick) begin
         day_count <= day_count + 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // alarm comparison on rising match
   assign match_now = wall_clock_counters == match_time &&
                      (!rtc_control_reg[CTRL_DAY_CMP] || day_count == match_day_field);

   // counters and alarm both reset to zero, so start as matched: no event out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_prev <= 1'b1;
      end else begin
         match_prev <= match_now;
      end
   end

   // stopwatch counts minutes down to minus one and stays
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopw <= STOPW_EXPD;
      end else if (wr && paddr == ADDR_STOPW) begin
         stopw <= pwdata[5:0];
      end else if (min_tick && stopw != STOPW_EXPD) begin
         stopw <= stopw - 6'h01;
      end
   end

   // watchdog counts ticks; write restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_en       <= 1'b1;
         wdog_irq_mode <= 1'b0;
         wdog_cnt      <= '0;
      end else if (wr && paddr == ADDR_WDOG) begin
         wdog_en       <= pwdata[WDOG_EN];
         wdog_irq_mode <= pwdata[WDOG_IRQ_MODE];
         wdog_cnt      <= '0;
      end else if (wdog_expire) begin
         wdog_cnt <= '0;
      end else if (per_second_tick && wdog_en) begin
         wdog_cnt <= wdog_cnt + 2'h1;
      end
   end

   assign wdog_expire = wdog_en && wdog_cnt == WDOG_LIMIT;

   // system reset pulse from watchdog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_reset <= 1'b0;
      end else begin
         wdog_reset <= wdog_expire && !wdog_irq_mode;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // event collection, fifteen sources
   always_comb begin
      events          = '0;
      events[EV_SW]   = min_tick && (stopw == 6'h00 || stopw == STOPW_EXPD);
      events[EV_MIN]  = min_tick;
      events[EV_ALM]  = match_now && !match_prev;
      events[EV_DAY]  = day_tick;
      events[EV_SEC]  = per_second_tick && rtc_control_reg[CTRL_RTC_EN];
      events[EV_HR]   = hour_tick;
      events[EV_WDOG] = wdog_expire && wdog_irq_mode;
      events[EV_RTE0 +: N_RATES] = rate_ev;
   end

   // sticky flags; a new event beats a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_irq_status_reg <= '0;
      end else if (wr && paddr == ADDR_STATUS) begin
         rtc_irq_status_reg <= (rtc_irq_status_reg & ~pwdata[EV_W-1:0]) | events;
      end else begin
         rtc_irq_status_reg <= rtc_irq_status_reg | events;
      end
   end

   // three interrupt lines from enabled flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_rtc  <= 1'b0;
         irq_rt   <= 1'b0;
         irq_wdog <= 1'b0;
      end else begin
         irq_rtc  <= |(rtc_irq_status_reg & rtc_irq_enable_reg & MASK_RTC);
         irq_rt   <= |(rtc_irq_status_reg & rtc_irq_enable_reg & MASK_RT);
         irq_wdog <= |(rtc_irq_status_reg & rtc_irq_enable_reg & MASK_WDOG);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_control_reg    <= 8'h80;
         rtc_irq_enable_reg <= '0;
         match_time         <= '0;
         match_day_field    <= '0;
      end else if (wr) begin
         unique case (paddr)
            ADDR_CTRL:      rtc_control_reg    <= pwdata[7:0];
            ADDR_IRQ_EN:    rtc_irq_enable_reg <= pwdata[EV_W-1:0];
            ADDR_MATCH: begin
               match_time.hours   <= pwdata[HOUR_LO +: 5];
               match_time.minutes <= pwdata[MIN_LO +: 6];
               match_time.seconds <= pwdata[SEC_LO +: 6];
            end
            ADDR_MATCH_DAY: match_day_field    <= pwdata[DAY_W-1:0];
            default: ;
         endcase
      end
   end

   // read mux; reads have no side effects on the counters
   always_comb begin
      next_prdata = '0;
      unique case (paddr)
         ADDR_TIME: begin
            next_prdata[HOUR_LO +: 5] = wall_clock_counters.hours;
            next_prdata[MIN_LO +: 6]  = wall_clock_counters.minutes;
            next_prdata[SEC_LO +: 6]  = wall_clock_counters.seconds;
         end
         ADDR_MATCH: begin
            next_prdata[HOUR_LO +: 5] = match_time.hours;
            next_prdata[MIN_LO +: 6]  = match_time.minutes;
            next_prdata[SEC_LO +: 6]  = match_time.seconds;
         end
         ADDR_WDOG: begin
            next_prdata[WDOG_EN]          = wdog_en;
            next_prdata[WDOG_IRQ_MODE]    = wdog_irq_mode;
            next_prdata[WDOG_CNT_LO +: 2] = wdog_cnt;
         end
         ADDR_CTRL:      next_prdata[7:0]       = rtc_control_reg;
         ADDR_STATUS:    next_prdata[EV_W-1:0]  = rtc_irq_status_reg;
         ADDR_IRQ_EN:    next_prdata[EV_W-1:0]  = rtc_irq_enable_reg;
         ADDR_STOPW:     next_prdata[5:0]       = stopw;
         ADDR_DAY:       next_prdata[DAY_W-1:0] = day_count;
         ADDR_MATCH_DAY: next_prdata[DAY_W-1:0] = match_day_field;
         default: ;
      endcase
   end

   // apb answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sec_wrap;
      per_second_tick && rtc_control_reg[CTRL_RTC_EN] && wall_clock_counters.seconds == SEC_MAX && !wr;
   endsequence

   sequence s_midnight;
      s_sec_wrap ##0 wall_clock_counters.minutes == MIN_MAX ##0 wall_clock_counters.hours == 5'h17;
   endsequence

   a_sec_rollover: assert property (s_sec_wrap |=> wall_clock_counters.seconds == 6'h00 &&
                                   rtc_irq_status_reg[EV_MIN])
      else $error("seconds did not roll over");

   a_hour_midnight: assert property (s_midnight |=> wall_clock_counters.hours == 5'h00 &&
                                    day_count == $past(day_count) + 9'h001 && rtc_irq_status_reg[EV_DAY])
      else $error("midnight rollover wrong");

   a_time_write: assert property (wr && paddr == ADDR_TIME |=>
                                 wall_clock_counters.seconds == $past(pwdata[5:0]))
      else $error("time write not applied");

   a_range_clear: assert property (per_second_tick && rtc_control_reg[CTRL_RTC_EN] && !wr &&
                                  wall_clock_counters.seconds > SEC_MAX |=> wall_clock_counters.seconds == 6'h00)
      else $error("out of range seconds not cleared");

   a_flag_sticky: assert property (rtc_irq_status_reg[EV_ALM] && !(wr && paddr == ADDR_STATUS)
                                  |=> rtc_irq_status_reg[EV_ALM])
      else $error("flag dropped without clear");

   a_alarm_flag: assert property (match_now && !match_prev |=> rtc_irq_status_reg[EV_ALM])
      else $error("alarm match not flagged");

   a_irq_rtc_line: assert property (|(rtc_irq_status_reg & rtc_irq_enable_reg & MASK_RTC)
                                   |=> irq_rtc)
      else $error("rtc line not asserted");

   a_irq_masked: assert property ((rtc_irq_enable_reg & MASK_RT) == '0 ##1
                                 (rtc_irq_enable_reg & MASK_RT) == '0 |-> !irq_rt)
      else $error("masked rate line asserted");

   a_tick_spacing: assert property (per_second_tick |=> !per_second_tick [*8])
      else $error("ticks too close");

   a_wdog_reset: assert property (wdog_expire && !wdog_irq_mode |=> wdog_reset)
      else $error("watchdog reset missing");

   a_disabled_hold: assert property (!rtc_control_reg[CTRL_RTC_EN] && !wr |=>
                                    wall_clock_counters == $past(wall_clock_counters))
      else $error("counters moved while disabled");

   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

endmodule

// ==== verification/rtca_ref_src.sv ====
module rtca_ref_src
   import rtca_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [7:0] edges,
   output logic            slow_ref_clock,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] half_left;
   logic [1:0] phase;

   // crystal burst of rising edges, line stays low between bursts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_left      <= 9'h0;
         phase          <= 2'h0;
         slow_ref_clock <= 1'b0;
      end else if (start) begin
         half_left <= {edges, 1'b0};
         phase     <= 2'h0;
      end else if (half_left != 9'h0) begin
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            slow_ref_clock <= ~slow_ref_clock;
            half_left      <= half_left - 9'h1;
         end
      end
   end

   // burst still in progress
   assign busy = start | (half_left != 9'h0);
endmodule

// ==== verification/rtca_core_test.sv ====
module rtca_core_test
   import rtca_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, edges;
   logic [31:0] pwdata, prdata;
   logic        ref_clk, start, busy, irq_wdog, irq_rt, irq_rtc, wdog_reset;
   int          num_errors, n_tests, n_wrst, h, m, s, d, sw, ah, am, as_, div, i, n_ref;
   int          seed = 32'hb5e2;
   int unsigned ru;
   logic [15:0] st, en;
   logic [31:0] r;
   logic        e;

   rtca_core #(.DIV_LOW(4), .DIV_HIGH(5)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slow_ref_clock(ref_clk), .irq_wdog(irq_wdog),
      .irq_rt(irq_rt), .irq_rtc(irq_rtc), .wdog_reset(wdog_reset));
   rtca_ref_src u_ref (.pclk(pclk), .presetn(presetn), .start(start), .edges(edges),
      .slow_ref_clock(ref_clk), .busy(busy));

   ////////////////////////////////////////////////////////////
   // clock and reset-pulse counter
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) if (wdog_reset === 1'b1) n_wrst++;

   ////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv,
            output logic er);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin num_errors++; close_out; end
      rdv = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, r, e);
   endtask
   function automatic bit eq();
      return h == ah && m == am && s == as_;
   endfunction
   function automatic int inc(int v, int mx, output bit c);
      c = (v == mx);
      return (v >= mx) ? 0 : v + 1;
   endfunction
   // model of one per-second step
   task step;
      bit c, b;
      b = eq(); st[EV_SEC] = 1;
      s = inc(s, 59, c);
      if (c) begin
         st[EV_MIN] = 1;
         if (sw == 0 || sw == 63) st[EV_SW] = 1;
         if (sw != 63) sw = (sw - 1) & 63;
         m = inc(m, 59, c);
         if (c) begin
            st[EV_HR] = 1; h = inc(h, 23, c);
            if (c) begin st[EV_DAY] = 1; d = (d + 1) % 512; end
         end
      end
      if (eq() && !b) st[EV_ALM] = 1;
   endtask
   task set_t(input int hh, input int mm, input int ss, input bit match_event_flag);
      bit b;
      b = eq();
      wr(match_event_flag ? ADDR_MATCH : ADDR_TIME, {3'h0, 5'(hh), 2'h0, 6'(mm), 10'h0, 6'(ss)});
      if (match_event_flag) begin ah = hh; am = mm; as_ = ss; end
      else begin h = hh; m = mm; s = ss; end
      if (eq() && !b) st[EV_ALM] = 1;
   endtask
   // send reference edges, then model nt ticks
   task run(input int ne, input int nt);
      int k;
      start <= 1'b1; edges <= 8'(ne);
      @(posedge pclk);
      start <= 1'b0; k = 0;
      do begin @(posedge pclk); k++; end while (busy !== 1'b0 && k < 2000);
      if (k >= 2000) begin num_errors++; close_out; end
      repeat (8) @(posedge pclk);
      // rate 0 fires each time the edge total crosses a multiple of its period
      if (n_ref % (1 << RATE_TAP0) + ne >= (1 << RATE_TAP0)) st[EV_RTE0] = 1;
      n_ref += ne;
      repeat (nt) step();
   endtask
   task chk_all;
      apb(1'b0, ADDR_TIME, 32'h0, r, e);
      chk("time", r, {3'h0, 5'(h), 2'h0, 6'(m), 10'h0, 6'(s)});
      apb(1'b0, ADDR_DAY, 32'h0, r, e);
      chk("day", r, 32'(d));
      apb(1'b0, ADDR_STATUS, 32'h0, r, e);
      chk("status", r & 32'h01bf, {16'h0, st & 16'h01bf});
      chk("irq_rtc", irq_rtc, |(st[5:0] & en[5:0]));
      chk("irq_wdog", irq_wdog, st[EV_WDOG] & en[EV_WDOG]);
      chk("irq_rt", irq_rt, st[EV_RTE0] & en[EV_RTE0]);
   endtask
   task clr;
      wr(ADDR_STATUS, 32'hffff); st = 16'h0;
   endtask
   task ien(input logic [15:0] v);
      wr(ADDR_IRQ_EN, {16'h0, v}); en = v;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, start, edges} = '0;
      {num_errors, n_tests, n_wrst, h, m, s, d, ah, am, as_, n_ref} = '0;
      sw = 63; st = 16'h0; en = 16'h0; div = 4;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values and unmapped access
      apb(1'b0, ADDR_CTRL, 32'h0, r, e);
      chk("ctrl", r, 32'h80);
      apb(1'b0, ADDR_STOPW, 32'h0, r, e);
      chk("stopw", r, 32'h3f);
      apb(1'b0, 8'h24, 32'h0, r, e);
      chk("unmapped", {r[30:0], e}, 32'h1);
      wr(ADDR_WDOG, 32'h0);
      chk_all;
      $display("test reset done");
      // midnight with day wrap, then mask and clear
      ien(16'h003f);
      set_t(23, 59, 59, 0);
      wr(ADDR_DAY, 32'h1ff); d = 511;
      run(div, 1); chk_all;
      ien(16'h0); chk_all;
      ien(16'h003f); clr; chk_all;
      $display("test rollover done");
      // out-of-range values
      set_t(26, 59, 62, 0); run(div, 1); chk_all;
      set_t(26, 59, 59, 0); run(div, 1); chk_all;
      $display("test range done");
      // random times near carries, reads mid-count
      for (i = 0; i < 6; i++) begin
         ru = $random(seed);
         set_t(ru % 24, 56 + (ru >> 8) % 4, 57 + (ru >> 16) % 3, 0);
         run(div * (1 + (ru >> 20) % 3), 1 + (ru >> 20) % 3); chk_all;
      end
      $display("test random done");
      // alarm fires again, then unenabled
      set_t(1, 2, 3, 1);
      for (i = 0; i < 3; i++) begin
         clr; ien(i < 2 ? 16'h0004 : 16'h0);
         set_t(1, 2, 2, 0); run(div, 1); chk_all;
      end
      $display("test alarm done");
      // higher reference divisor
      wr(ADDR_CTRL, 32'ha0); div = 5;
      run(4, 0); chk_all;
      run(1, 1); chk_all;
      wr(ADDR_CTRL, 32'h80); div = 4;
      $display("test divisor done");
      // watchdog reset then interrupt mode
      clr; n_wrst = 0; wr(ADDR_WDOG, 32'h1);
      run(2 * div, 2);
      chk("wdog_reset", n_wrst, 1);
      wr(ADDR_WDOG, 32'h3); ien(16'h0080);
      run(2 * div, 2); st[EV_WDOG] = 1; chk_all;
      wr(ADDR_WDOG, 32'h0);
      $display("test watchdog done");
      // periodic rate line, rate 0 only
      ien(16'h0100); run(1 << RATE_TAP0, (1 << RATE_TAP0) / div); chk_all;
      $display("test rate done");
      // block disabled holds the count
      wr(ADDR_CTRL, 32'h0); run(2 * div, 0); chk_all;
      $display("test disable done");
      close_out;
   end
endmodule
